// ### inc/brq_pkg.sv
// Constants for the burst read query table: table indexes, fixed
// entry values, own control register layout.
// Assumes an APB slave that maps index N to byte address 4*N.
package brq_pkg;
  // Table indexes (byte address is four times the index)
  localparam logic [9:0] IDX_WORD_WIDTH = 10'h028;
  localparam logic [9:0] IDX_PAGE_SIZE = 10'h127;
  localparam logic [9:0] IDX_CFG_COUNT = 10'h128;
  localparam logic [9:0] IDX_OPT_ONE = 10'h129;
  localparam logic [9:0] IDX_OPT_TWO = 10'h12A;
  localparam logic [9:0] IDX_OPT_THREE = 10'h12B;
  localparam logic [9:0] IDX_OPT_FOUR = 10'h12C;
  localparam logic [9:0] IDX_PART_COUNT = 10'h12D;
  localparam logic [9:0] IDX_READ_CFG = 10'h100;
  localparam logic [9:0] IDX_BURST_STAT = 10'h101;
  // Fixed entry values
  localparam logic [7:0] VAL_PAGE_SIZE = 8'h03;
  localparam logic [7:0] VAL_NO_PAGE = 8'h00;
  localparam logic [7:0] VAL_CFG_COUNT = 8'h04;
  localparam logic [7:0] VAL_OPT_ONE = 8'h01;
  localparam logic [7:0] VAL_OPT_TWO = 8'h02;
  localparam logic [7:0] VAL_OPT_THREE = 8'h03;
  localparam logic [7:0] VAL_OPT_FOUR = 8'h07;
  localparam logic [2:0] BURST_CONT = 3'h7;
  // Read configuration register: burst length field
  localparam int RCFG_LEN_LSB = 0;
  localparam int RCFG_LEN_W = 3;
  localparam logic [2:0] RCFG_RESET = 3'h7;
  // Burst status register fields
  localparam int STAT_WORDS_LSB = 0;
  localparam int STAT_CONT_BIT = 8;
  localparam int STAT_SUPP_BIT = 9;
endpackage

// ### logic/brq_query_table.sv
// Burst read query table behind an APB slave, plus a small burst
// length configuration register and its decoded status.
// Assumes an APB master on sys_clk; no wait states on any access.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none

module brq_query_table #(
  parameter int ADDR_W = 12,
  parameter logic [7:0] WORD_WIDTH_CODE = 8'h01,
  parameter logic [7:0] PART_REGIONS = 8'h01
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] burstWords,
  output logic burstCont,
  output logic burstSupported
);

  // Elaboration stops on an address width the decode cannot serve
  if (ADDR_W < 12 || ADDR_W > 32) begin : gen_addr_chk
    $error("ADDR_W must lie between 12 and 32");
  end

  ////////////////////////////////////////////////////////////////////
  // Address decode

  logic [9:0] regIdx;
  logic aligned;
  logic setupPhase;
  logic accDone;

  assign regIdx = paddr[11:2];
  // Upper address bits must be clear, so the table never aliases
  assign aligned = (paddr[1:0] == 2'h0) && ((paddr >> 12) == '0);
  assign setupPhase = psel && !penable;
  assign accDone = psel && penable && pready;

  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [2:0] burstLen_q, burstLen_d;
  logic [7:0] burstWords_q, burstWords_d;
  logic burstCont_q, burstCont_d;
  logic burstSupported_q, burstSupported_d;

  // Table data is picked in setup so the answer leaves a flip-flop
  // Costs a fixed access cycle but keeps prdata off the address path
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = setupPhase;
    if (setupPhase) begin
      prdata_d = 32'h0000_0000;
      if (!aligned) begin
        pslverr_d = 1'b1;
      end else if (regIdx == brq_pkg::IDX_PAGE_SIZE) begin
        prdata_d[7:0] = brq_pkg::VAL_PAGE_SIZE;
        pslverr_d = pwrite;
      end else if (regIdx == brq_pkg::IDX_CFG_COUNT) begin
        prdata_d[7:0] = brq_pkg::VAL_CFG_COUNT;
        pslverr_d = pwrite;
      end else if (regIdx == brq_pkg::IDX_OPT_ONE) begin
        prdata_d[7:0] = brq_pkg::VAL_OPT_ONE;
        pslverr_d = pwrite;
      end else if (regIdx == brq_pkg::IDX_OPT_TWO) begin
        prdata_d[7:0] = brq_pkg::VAL_OPT_TWO;
        pslverr_d = pwrite;
      end else if (regIdx == brq_pkg::IDX_OPT_THREE) begin
        prdata_d[7:0] = brq_pkg::VAL_OPT_THREE;
        pslverr_d = pwrite;
      end else if (regIdx == brq_pkg::IDX_OPT_FOUR) begin
        prdata_d[7:0] = brq_pkg::VAL_OPT_FOUR;
        pslverr_d = pwrite;
      end else if (regIdx == brq_pkg::IDX_PART_COUNT) begin
        prdata_d[7:0] = PART_REGIONS;
        pslverr_d = pwrite;
      end else if (regIdx == brq_pkg::IDX_WORD_WIDTH) begin
        prdata_d[7:0] = WORD_WIDTH_CODE;
        pslverr_d = pwrite;
      end else if (regIdx == brq_pkg::IDX_READ_CFG) begin
        prdata_d[brq_pkg::RCFG_LEN_LSB +: brq_pkg::RCFG_LEN_W] = burstLen_q;
      end else if (regIdx == brq_pkg::IDX_BURST_STAT) begin
        prdata_d[brq_pkg::STAT_WORDS_LSB +: 8] = burstWords_q;
        prdata_d[brq_pkg::STAT_CONT_BIT] = burstCont_q;
        prdata_d[brq_pkg::STAT_SUPP_BIT] = burstSupported_q;
        pslverr_d = pwrite;
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////
  // Burst length configuration and decode

  // Writes land only at the completing edge, never in setup
  // n = 0 is taken as written but flagged unsupported; host must check
  always_comb begin
    burstLen_d = burstLen_q;
    if (accDone && pwrite && aligned && regIdx == brq_pkg::IDX_READ_CFG) begin
      burstLen_d = pwdata[brq_pkg::RCFG_LEN_LSB +: brq_pkg::RCFG_LEN_W];
    end
  end

  // Decoded from the new value so status changes at the same edge as the write
  always_comb begin
    burstCont_d = (burstLen_d == brq_pkg::BURST_CONT);
    burstWords_d = 8'h00;
    if (!burstCont_d) begin
      burstWords_d = 8'(16'h0002 << burstLen_d);
    end
    burstSupported_d = (burstLen_d == brq_pkg::VAL_OPT_ONE[2:0]) ||
                       (burstLen_d == brq_pkg::VAL_OPT_TWO[2:0]) ||
                       (burstLen_d == brq_pkg::VAL_OPT_THREE[2:0]) ||
                       (burstLen_d == brq_pkg::VAL_OPT_FOUR[2:0]);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      burstLen_q <= brq_pkg::RCFG_RESET;
      burstWords_q <= 8'h00;
      burstCont_q <= 1'b1;
      burstSupported_q <= 1'b1;
    end else begin
      burstLen_q <= burstLen_d;
      burstWords_q <= burstWords_d;
      burstCont_q <= burstCont_d;
      burstSupported_q <= burstSupported_d;
    end
  end

  assign burstWords = burstWords_q;
  assign burstCont = burstCont_q;
  assign burstSupported = burstSupported_q;

  ////////////////////////////////////////////////////////////////////
  // Checks

  logic readDone;
  assign readDone = accDone && !pwrite && aligned;

  pageSize_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx == brq_pkg::IDX_PAGE_SIZE |->
      prdata == 32'h0000_0003 && (32'h1 << prdata[7:0]) == 32'h8 && !pslverr)
    else $error("Page size entry is not 03");

  cfgCount_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx == brq_pkg::IDX_CFG_COUNT |-> prdata == 32'h0000_0004)
    else $error("Burst option count is not 04");

  optResv_bits_a: assert property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx >= brq_pkg::IDX_OPT_ONE && regIdx <= brq_pkg::IDX_OPT_FOUR
      |-> prdata[31:3] == '0)
    else $error("Reserved option bits are set");

  contMode_decode_a: assert property (@(posedge sys_clk) disable iff (srst)
    accDone && pwrite && aligned && regIdx == brq_pkg::IDX_READ_CFG
      && pwdata[2:0] == 3'h7 |=> burstCont && burstWords == 8'h00 && burstSupported)
    else $error("Length 7 not decoded as continuous");

  lenCopy_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    accDone && pwrite && aligned && regIdx == brq_pkg::IDX_READ_CFG
      && pwdata[2:0] == 3'h2 |=> burstWords == 8'h08 ##1 burstWords == 8'h08)
    else $error("Length 2 not decoded as 8 words");

  optValues_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx == brq_pkg::IDX_OPT_THREE |-> prdata[7:0] == 8'h03
      && $past(regIdx, 1) == brq_pkg::IDX_OPT_THREE)
    else $error("Third option entry is not 03");

  widthEntry_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx == brq_pkg::IDX_WORD_WIDTH |-> prdata[7:0] == WORD_WIDTH_CODE)
    else $error("Word width entry mismatch");

  partCount_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx == brq_pkg::IDX_PART_COUNT |-> prdata[7:0] == PART_REGIONS)
    else $error("Partition region count mismatch");

  tableWrite_refused_a: assert property (@(posedge sys_clk) disable iff (srst)
    accDone && pwrite && aligned && regIdx >= brq_pkg::IDX_PAGE_SIZE
      && regIdx <= brq_pkg::IDX_PART_COUNT |-> pslverr ##1 !pready)
    else $error("Table write not refused");

  readyOne_cycle_a: assert property (@(posedge sys_clk) disable iff (srst)
    setupPhase |=> pready ##1 (!pready || !penable))
    else $error("Ready not a single access cycle");

  // Sampled reset in the antecedent keeps the release edge out
  cfgHold_stable_a: assert property (@(posedge sys_clk) disable iff (srst)
    !srst && !(accDone && pwrite) |=> $stable(burstWords))
    else $error("Burst decode changed without a write");

  // Every table entry gets its own check so one bad constant names itself
  optOne_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx == brq_pkg::IDX_OPT_ONE
      |-> prdata == 32'h0000_0001 && !pslverr)
    else $error("First option entry is not 01");

  optTwo_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx == brq_pkg::IDX_OPT_TWO
      |-> prdata == 32'h0000_0002 && !pslverr)
    else $error("Second option entry is not 02");

  optFour_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx == brq_pkg::IDX_OPT_FOUR
      |-> prdata == 32'h0000_0007 && !pslverr)
    else $error("Fourth option entry is not 07");

  widthWrite_refused_a: assert property (@(posedge sys_clk) disable iff (srst)
    accDone && pwrite && aligned && regIdx == brq_pkg::IDX_WORD_WIDTH |-> pslverr)
    else $error("Word width write not refused");

  statWrite_refused_a: assert property (@(posedge sys_clk) disable iff (srst)
    accDone && pwrite && aligned && regIdx == brq_pkg::IDX_BURST_STAT
      |-> pslverr ##1 $stable(burstWords))
    else $error("Status write not refused");

  // Bad addresses answer with an error and an all-zero word
  badAlign_err_a: assert property (@(posedge sys_clk) disable iff (srst)
    accDone && paddr[1:0] != 2'h0
      |-> pslverr && prdata == 32'h0000_0000)
    else $error("Unaligned access not refused");

  cfgRead_value_a: assert property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx == brq_pkg::IDX_READ_CFG
      |-> prdata[31:3] == '0 && prdata[2:0] == burstLen_q && !pslverr)
    else $error("Length field read back wrong");

  statRead_value_a: assert property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx == brq_pkg::IDX_BURST_STAT
      |-> prdata[31:10] == '0 && prdata[7:0] == burstWords && prdata[8] == burstCont)
    else $error("Status read back wrong");

  // Read data only moves at a setup edge; hosts may sample it late
  prdataHold_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
    !srst && !setupPhase |=> $stable(prdata))
    else $error("Read data moved outside a setup edge");

  readyIdle_low_a: assert property (@(posedge sys_clk) disable iff (srst)
    !psel |=> !pready && !pslverr)
    else $error("Ready or error without a select");

  errWith_ready_a: assert property (@(posedge sys_clk) disable iff (srst)
    pslverr |-> pready)
    else $error("Error shown outside the access cycle");

  lenFour_decode_a: assert property (@(posedge sys_clk) disable iff (srst)
    burstLen_q == 3'h1 |-> burstWords == 8'h04 && !burstCont && burstSupported)
    else $error("Length 1 not decoded as 4 words");

  lenEight_decode_a: assert property (@(posedge sys_clk) disable iff (srst)
    burstLen_q == 3'h2 |-> burstWords == 8'h08 && !burstCont && burstSupported)
    else $error("Length 2 not decoded as 8 words");

  lenSixteen_decode_a: assert property (@(posedge sys_clk) disable iff (srst)
    burstLen_q == 3'h3 |-> burstWords == 8'h10 && !burstCont && burstSupported)
    else $error("Length 3 not decoded as 16 words");

  lenZero_decode_a: assert property (@(posedge sys_clk) disable iff (srst)
    burstLen_q == 3'h0 |-> burstWords == 8'h02 && !burstCont && !burstSupported)
    else $error("Length 0 not decoded as unsupported");

  cont_read_c: cover property (@(posedge sys_clk) disable iff (srst)
    readDone && regIdx == brq_pkg::IDX_OPT_FOUR);
  cfg_write_c: cover property (@(posedge sys_clk) disable iff (srst)
    accDone && pwrite && regIdx == brq_pkg::IDX_READ_CFG);
  unmapped_c: cover property (@(posedge sys_clk) disable iff (srst)
    accDone && pslverr && !pwrite);
  back_to_back_c: cover property (@(posedge sys_clk) disable iff (srst)
    accDone ##1 (psel && !penable) ##1 accDone);
  len_zero_c: cover property (@(posedge sys_clk) disable iff (srst)
    accDone && pwrite && regIdx == brq_pkg::IDX_READ_CFG && pwdata[2:0] == 3'h0);

endmodule

`default_nettype wire

// ### verification/brq_host_model.sv
// Host side APB master that reads the query table.
// Assumes one sys_clk; callers run one transfer at a time.
`timescale 1ns/1ns
`default_nettype none

module brq_host_model (
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////
  // Request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/brq_query_table_tb.sv
// Self-checking bench for the query table and its burst length register.
// Assumes the host model as the only APB master.
`timescale 1ns/1ns
`default_nettype none

module brq_query_table_tb;
  localparam logic [7:0] WW = 8'h01;
  localparam logic [7:0] PR = 8'h00;
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] burstWords;
  logic burstCont, burstSupported;
  int mismatches = 0;
  int samplesChecked = 0;
  logic [11:0] adr [8] = '{12'h0A0, 12'h49C, 12'h4A0, 12'h4A4, 12'h4A8, 12'h4AC,
                           12'h4B0, 12'h4B4};
  logic [7:0] val [8] = '{WW, 8'h03, 8'h04, 8'h01, 8'h02, 8'h03, 8'h07, PR};
  logic [2:0] opt [5] = '{3'h0, 3'h1, 3'h7, 3'h2, 3'h3};

  brq_query_table #(.WORD_WIDTH_CODE(WW), .PART_REGIONS(PR)) dut (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .burstWords(burstWords),
    .burstCont(burstCont), .burstSupported(burstSupported));
  brq_host_model host (
    .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic testTable;
    for (int i = 0; i < 8; i++) begin
      host.xfer(1'b0, adr[i], 32'h0, rd, err);
      chk(rd, {24'h0, val[i]});
      chk({31'h0, err}, 32'h0);
    end
    $display("table read test done");
  endtask
  task automatic testRefuse;
    for (int i = 0; i < 8; i++) begin
      host.xfer(1'b1, adr[i], 32'hFFFF_FFFF, rd, err);
      chk({31'h0, err}, 32'h1);
      host.xfer(1'b0, adr[i], 32'h0, rd, err);
      chk(rd, {24'h0, val[i]});
    end
    $display("table write test done");
  endtask
  task automatic testBurst;
    logic [7:0] w;
    logic [31:0] e;
    chk({22'h0, burstSupported, burstCont, burstWords}, 32'h0000_0300);
    for (int i = 0; i < 5; i++) begin
      w = (opt[i] == 3'h7) ? 8'h00 : 8'h01 << (opt[i] + 3'h1);
      e = {22'h0, opt[i] != 3'h0, opt[i] == 3'h7, w};
      host.xfer(1'b1, 12'h400, {29'h0, opt[i]}, rd, err);
      chk({31'h0, err}, 32'h0);
      @(negedge sys_clk);
      chk({22'h0, burstSupported, burstCont, burstWords}, e);
      host.xfer(1'b0, 12'h400, 32'h0, rd, err);
      chk(rd, {29'h0, opt[i]});
      chk({31'h0, err}, 32'h0);
      host.xfer(1'b0, 12'h404, 32'h0, rd, err);
      chk(rd, e);
    end
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    chk({22'h0, burstSupported, burstCont, burstWords}, 32'h0000_0300);
    $display("burst config test done");
  endtask
  task automatic testBadAddr;
    host.xfer(1'b0, 12'h49D, 32'h0, rd, err);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h1);
    host.xfer(1'b0, 12'h4B8, 32'h0, rd, err);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h1);
    host.xfer(1'b1, 12'h404, 32'h1, rd, err);
    chk({31'h0, err}, 32'h1);
    host.xfer(1'b0, 12'h404, 32'h0, rd, err);
    chk(rd, 32'h0000_0300);
    $display("bad address test done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Whole run is under 150 cycles; generous margin
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
  initial begin
    srst = 1'b1;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    testTable();
    testRefuse();
    testBurst();
    testBadAddr();
    conclude();
  end
endmodule
`default_nettype wire
